/* verilog/dlws_params.svh */
// constants for the latency and write strobe control pair: offsets,
// field positions, reset values, per-band tables and cycle counts.
// assumes inclusion by bare name; counts are in link clock cycles, except the pclk divider steps DLWS_CK_LAST and DLWS_CK_MID.
`ifndef DLWS_PARAMS_SVH
`define DLWS_PARAMS_SVH

// ==========================================================
// host register offsets (apb byte addresses)
`define DLWS_OFF_CTRL 12'h000
`define DLWS_OFF_CMD 12'h004
`define DLWS_OFF_STATUS 12'h008

// ==========================================================
// host register fields
`define DLWS_CTRL_CKE 0
`define DLWS_CTRL_BAND 3:1
`define DLWS_CMD_CODE 2:0
`define DLWS_CMD_AP 3
`define DLWS_CMD_BL32 4
`define DLWS_CMD_MA 6:5
`define DLWS_CMD_OP 15:8

// ==========================================================
// device mode register selects and fields
`define DLWS_MA_LAT 2'h0
`define DLWS_MA_IO 2'h1
`define DLWS_MA_TERM 2'h2
`define DLWS_LAT_BAND 2:0
`define DLWS_LAT_WLSET 6
`define DLWS_LAT_WMODE 7
`define DLWS_IO_WPST 1
`define DLWS_IO_DBI 6
`define DLWS_TERM_ODT 2:0
`define DLWS_RST_REG 8'h00

// ==========================================================
// per-band tables, band 0 in the low byte
`define DLWS_TBL_RL 64'h24201C18140E0A06
`define DLWS_TBL_RL_DBI 64'h2824201C16100C06
`define DLWS_TBL_WL_A 64'h12100E0C0A080604
`define DLWS_TBL_WL_B 64'h221E1A16120C0804
`define DLWS_TBL_NWR 64'h28221E1814100A06
`define DLWS_TBL_READ_TO_PRECHARGE_CYCLES 64'h100E0C0A08080808
`define DLWS_TBL_ON_A 64'h0806060404000000
`define DLWS_TBL_ON_B 64'h1814120E0C060000
`define DLWS_TBL_OFF_A 64'h24211E1B1815120F
`define DLWS_TBL_OFF_B 64'h342F2A252019140F

// ==========================================================
// cycle counts
`define DLWS_HALF16 8'h08
`define DLWS_BL32_ADD 8'h08
`define DLWS_WPRE 8'h02
`define DLWS_TURN 8'h01
`define DLWS_POST_STD 8'h01
`define DLWS_POST_EXT 8'h02
`define DLWS_ONE 8'h01
`define DLWS_CK_LAST 4'hF
`define DLWS_CK_MID 4'h7

`endif

/* verilog/dlws_pkg.sv */
// types and table lookups shared by both ends of the strobe link.
// assumes dlws_params.svh is on the include path.
package dlws_pkg;
`include "dlws_params.svh"

	// ==========================================================
	// link command codes
	typedef enum logic [2:0] {
		cmd_des,
		cmd_wr,
		cmd_mwr,
		cmd_rd,
		cmd_mrw
	} dlws_cmd_e;

	typedef logic [7:0] dlws_cnt_t;

	// pick one band's byte out of a packed table
	function automatic dlws_cnt_t dlws_pick(input logic [63:0] tbl,
		input logic [2:0] band);
		return tbl[{band, 3'b000} +: 8];
	endfunction

	// data cycles of a burst: 16 beats take 8 clocks, 32 take 16
	function automatic dlws_cnt_t dlws_half(input logic bl32);
		return bl32 ? dlws_cnt_t'(`DLWS_HALF16 + `DLWS_HALF16) : `DLWS_HALF16;
	endfunction

	// exception window after a read; the extra gap n is taken as 0,
	// the worst case, since neither end knows the minimum gap
	function automatic dlws_cnt_t dlws_exc(input logic odt,
		input dlws_cnt_t wl, input dlws_cnt_t on);
		dlws_cnt_t a;
		a = wl + `DLWS_TURN;
		if (odt)
			return `DLWS_TURN;
		if (a > dlws_cnt_t'(on + `DLWS_WPRE))
			return dlws_cnt_t'(a - on - `DLWS_WPRE);
		return 8'h00;
	endfunction
endpackage

/* verilog/dlws_link_if.sv */
// link between the memory controller end and the dram end.
// assumes both ends run on pclk; ck here is a slow divided clock.
`timescale 1ns/100ps
interface dlws_link_if;
	logic ck; // link clock made by the host
	logic cke; // clock enable
	logic cs; // command strobe, one ck cycle
	logic [2:0] cmd; // command code
	logic ap; // auto precharge
	logic bl32; // 32-beat burst
	logic [1:0] ma; // mode register select
	logic [7:0] op; // mode register data
	logic h_t, h_c, h_oe; // host strobe drive
	logic d_t, d_c, d_oe; // device strobe drive
	logic dqs_t, dqs_c; // resolved strobe pair

	// an undriven pair is pulled low by termination, so not differential
	assign dqs_t = h_oe ? h_t : (d_oe ? d_t : 1'b0);
	assign dqs_c = h_oe ? h_c : (d_oe ? d_c : 1'b0);

	modport host(output ck, cke, cs, cmd, ap, bl32, ma, op, h_t, h_c, h_oe,
		input dqs_t, dqs_c);
	modport device(input ck, cke, cs, cmd, ap, bl32, ma, op, dqs_t, dqs_c,
		output d_t, d_c, d_oe);
endinterface

/* verilog/dlws_sync.sv */
// two-stage synchroniser for a bundle of link inputs.
// assumes the bundle changes no faster than a few pclk cycles.
`timescale 1ns/100ps
module dlws_sync #(
	parameter int W = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1; // first stage, read only by s2
		logic [W-1:0] s2; // second stage
	} dlws_sync_s;

	dlws_sync_s r, n;

	// ==========================================================
	// next state
	always_comb begin
		n = r;
		n.s1 = d;
		n.s2 = r.s1;
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end

	assign q = r.s2;
endmodule

/* verilog/dlws_dev.sv */
// dram end: mode registers, latency lookup, auto precharge timing,
// read strobe drive and write strobe watch.
// assumes the host makes ck far slower than pclk (16 pclk per ck).
// Contract
// - host keeps clock inside programmed band
// - read latency per band, dbi selects column
// - write latency set a or b by bit
// - write auto precharge waits write recovery count
// - read auto precharge waits read-to-precharge count
// - 32-beat reads add eight clocks
// - strobe control uses read-based or on/off mode
// - strobe needs never bend command timing; the host refuses commands until the write off delay has passed
// - read-based: write starts differential strobe drive
// - read-based: complement high again after postamble
// - read-based: cke low makes strobes don't-care
// - read-based: waived during read strobe, handover
// - on/off: differential from on delay to off
// - on/off: maximum on delay per band
// - on/off: minimum off delay per band
// - on/off: waived over reads and turnaround
// - toggling during bursts counts as differential
// - exception window from latency, turnaround, termination
// - termination applied only when field nonzero
// - write postamble half or one and half cycles; the code rounds it up to one or two whole cycles
`timescale 1ns/100ps
module dlws_dev import dlws_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	dlws_link_if.device link,
	output logic [7:0] lat_cfg,
	output logic [7:0] io_cfg,
	output logic [7:0] term_cfg,
	output logic [7:0] read_latency,
	output logic [7:0] write_latency,
	output logic odt_on,
	output logic wpst_ext,
	output logic precharge_start,
	output logic strobe_fault,
	output logic read_strobe_on
);
`include "dlws_params.svh"

	// ==========================================================
	// state
	typedef struct packed {
		logic ck_d; // last synced ck, for edge finding
		logic [7:0] lat; // latency_config_register
		logic [7:0] io; // io_config_register
		logic [7:0] term; // termination_config_register
		logic wr_act; // a write window is open
		dlws_cnt_t wr_age; // ck cycles since the last write
		logic wr_bl32;
		logic rd_act; // a read window is open
		dlws_cnt_t rd_age; // ck cycles since the last read
		logic rd_bl32;
		logic pc_act; // auto precharge pending
		dlws_cnt_t pc_cnt; // ck cycles left before precharge
		logic pc_go; // internal precharge start pulse
		logic dqs_t, dqs_c, dqs_oe; // read strobe drive
		logic fault; // sticky strobe violation
	} dlws_dev_s;

	dlws_dev_s r, n;

	logic s_ck, s_cke, s_cs, s_ap, s_bl32, s_t, s_c;
	logic [2:0] s_cmd;
	logic [1:0] s_ma;
	logic [7:0] s_op;
	logic [19:0] sq;
	logic tick; // rising ck edge seen in pclk domain
	logic diff; // strobe pair is differential
	logic rd_excl; // read, its postamble or turnaround
	logic [2:0] band;
	dlws_cnt_t rl, wl, write_recovery_cycles, read_to_precharge_cycles, on_d, off_d, exc, post;
	dlws_cnt_t wr_end, rd_end, burst_end;

	// ==========================================================
	// every link input crosses two flops before use
	dlws_sync #(.W(20)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({link.ck, link.cke, link.cs, link.cmd, link.ap, link.bl32,
			link.ma, link.op, link.dqs_t, link.dqs_c}),
		.q(sq)
	);
	assign {s_ck, s_cke, s_cs, s_cmd, s_ap, s_bl32, s_ma, s_op, s_t,
		s_c} = sq;
	assign tick = s_ck & ~r.ck_d;
	assign diff = s_t ^ s_c;

	// ==========================================================
	// latency lookup from the mode registers
	assign band = r.lat[`DLWS_LAT_BAND];
	assign rl = dlws_pick(r.io[`DLWS_IO_DBI] ? `DLWS_TBL_RL_DBI
		: `DLWS_TBL_RL, band);
	assign wl = dlws_pick(r.lat[`DLWS_LAT_WLSET] ? `DLWS_TBL_WL_B
		: `DLWS_TBL_WL_A, band);
	assign write_recovery_cycles = dlws_pick(`DLWS_TBL_NWR, band);
	assign read_to_precharge_cycles = dlws_pick(`DLWS_TBL_READ_TO_PRECHARGE_CYCLES, band);
	assign on_d = dlws_pick(r.lat[`DLWS_LAT_WLSET] ? `DLWS_TBL_ON_B
		: `DLWS_TBL_ON_A, band);
	assign off_d = dlws_pick(r.lat[`DLWS_LAT_WLSET] ? `DLWS_TBL_OFF_B
		: `DLWS_TBL_OFF_A, band);
	assign exc = dlws_exc(odt_on, wl, on_d);
	// postamble rounded up to whole ck cycles
	assign post = r.io[`DLWS_IO_WPST] ? `DLWS_POST_EXT
		: `DLWS_POST_STD;
	assign burst_end = wl + dlws_half(r.wr_bl32) + post;
	assign wr_end = (off_d > burst_end) ? off_d : burst_end;
	assign rd_end = rl + dlws_half(r.rd_bl32) + `DLWS_ONE + exc;

	// ==========================================================
	// next state: commands, timers, strobe drive and watch
	always_comb begin
		n = r;
		n.pc_go = 1'b0;
		n.ck_d = s_ck;
		rd_excl = 1'b0;
		if (tick) begin
			// age the open windows, one step per ck cycle
			if (r.wr_act) begin
				n.wr_age = r.wr_age + `DLWS_ONE;
				n.wr_act = (n.wr_age < wr_end);
			end
			if (r.rd_act) begin
				n.rd_age = r.rd_age + `DLWS_ONE;
				n.rd_act = (n.rd_age < rd_end);
			end
			if (r.pc_act) begin
				if (r.pc_cnt <= `DLWS_ONE) begin
					n.pc_go = 1'b1;
					n.pc_act = 1'b0;
				end else begin
					n.pc_cnt = r.pc_cnt - `DLWS_ONE;
				end
			end
			// a new command restarts its window; a later auto
			// precharge replaces one still pending
			if (s_cs) begin
				unique case (dlws_cmd_e'(s_cmd))
					cmd_wr, cmd_mwr: begin
						n.wr_act = 1'b1;
						n.wr_age = 8'h00;
						n.wr_bl32 = s_bl32;
						if (s_ap) begin
							n.pc_act = 1'b1;
							n.pc_cnt = wl + `DLWS_ONE + dlws_half(s_bl32)
								+ write_recovery_cycles;
						end
					end
					cmd_rd: begin
						n.rd_act = 1'b1;
						n.rd_age = 8'h00;
						n.rd_bl32 = s_bl32;
						if (s_ap) begin
							n.pc_act = 1'b1;
							n.pc_cnt = dlws_half(s_bl32) + read_to_precharge_cycles;
							if (s_bl32)
								n.pc_cnt = n.pc_cnt + `DLWS_BL32_ADD;
						end
					end
					cmd_mrw: begin
						unique case (s_ma)
							`DLWS_MA_LAT: n.lat = s_op;
							`DLWS_MA_IO: n.io = s_op;
							`DLWS_MA_TERM: n.term = s_op;
							default: ;
						endcase
					end
					cmd_des: ;
					default: ;
				endcase
			end
		end
		// read strobe: preamble at rl-1, toggles for the burst,
		// then one postamble cycle with the pair held apart
		n.dqs_oe = n.rd_act && (n.rd_age >= rl - `DLWS_ONE)
			&& (n.rd_age < rl + dlws_half(n.rd_bl32) + `DLWS_ONE);
		n.dqs_t = 1'b0;
		if (n.dqs_oe && n.rd_age >= rl
			&& n.rd_age < rl + dlws_half(n.rd_bl32))
			n.dqs_t = s_ck;
		n.dqs_c = n.dqs_oe & ~n.dqs_t;
		// read burst, postamble and turnaround are exempt; judged on
		// the ck cycle this tick opens, since the host moves its drive
		// at the ck fall before it and the old ages lag the pair
		rd_excl = n.dqs_oe | (n.rd_act && (n.rd_age >= rl - `DLWS_ONE)
			&& (n.rd_age < rd_end));
		// watch the write strobe once per ck cycle, mid-cycle; a mode
		// change taken at this tick already rules the pair seen now
		if (tick && !rd_excl) begin
			if (n.lat[`DLWS_LAT_WMODE]) begin
				// on/off mode: held apart from on to off delay;
				// toggling counts since it stays differential
				if (n.wr_act && n.wr_age >= on_d && n.wr_age < off_d
					&& !diff)
					n.fault = 1'b1;
			end else if (s_cke && !diff) begin
				// read-based mode: pair apart whenever cke is high,
				// don't-care while cke is low
				n.fault = 1'b1;
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.lat <= `DLWS_RST_REG;
			r.io <= `DLWS_RST_REG;
			r.term <= `DLWS_RST_REG;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// outputs
	assign link.d_t = r.dqs_t;
	assign link.d_c = r.dqs_c;
	assign link.d_oe = r.dqs_oe;
	assign lat_cfg = r.lat;
	assign io_cfg = r.io;
	assign term_cfg = r.term;
	assign read_latency = rl;
	assign write_latency = wl;
	assign odt_on = |r.term[`DLWS_TERM_ODT];
	assign wpst_ext = r.io[`DLWS_IO_WPST];
	assign precharge_start = r.pc_go;
	assign strobe_fault = r.fault;
	assign read_strobe_on = r.dqs_oe;
endmodule

/* verilog/dlws_host.sv */
// memory controller end: apb registers, link clock divider, command
// issue and write strobe drive for both strobe control modes.
// assumes software programs the dram through mrw commands issued here.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module dlws_host import dlws_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	dlws_link_if.host link
);
`include "dlws_params.svh"

	// ==========================================================
	// state
	typedef struct packed {
		logic [3:0] div; // ck divider, 16 pclk per ck
		logic ck;
		logic cke;
		logic [2:0] band_lim; // band that suits our ck rate
		logic pend; // command waiting for the next ck fall
		dlws_cmd_e p_cmd;
		logic p_ap, p_bl32;
		logic [1:0] p_ma;
		logic [7:0] p_op;
		logic cs; // link command fields
		dlws_cmd_e l_cmd;
		logic l_ap, l_bl32;
		logic [1:0] l_ma;
		logic [7:0] l_op;
		logic [7:0] lat, io, term; // shadows of the dram registers
		logic wr_act;
		dlws_cnt_t wr_age;
		logic wr_bl32;
		logic rd_act;
		dlws_cnt_t rd_age;
		logic rd_bl32;
		logic dqs_t, dqs_c, dqs_oe;
		logic [31:0] rdata;
		logic err; // answer of the pending apb access
	} dlws_host_s;

	dlws_host_s r, n;

	logic busy, band_ok, fall, wr_burst, rd_win, is_rw;
	logic [2:0] band;
	dlws_cnt_t rl, wl, on_d, off_d, exc, post, wr_end, rd_end;

	// ==========================================================
	// timing derived from the shadows
	assign band = r.lat[`DLWS_LAT_BAND];
	assign rl = dlws_pick(r.io[`DLWS_IO_DBI] ? `DLWS_TBL_RL_DBI
		: `DLWS_TBL_RL, band);
	assign wl = dlws_pick(r.lat[`DLWS_LAT_WLSET] ? `DLWS_TBL_WL_B
		: `DLWS_TBL_WL_A, band);
	assign on_d = dlws_pick(r.lat[`DLWS_LAT_WLSET] ? `DLWS_TBL_ON_B
		: `DLWS_TBL_ON_A, band);
	assign off_d = dlws_pick(r.lat[`DLWS_LAT_WLSET] ? `DLWS_TBL_OFF_B
		: `DLWS_TBL_OFF_A, band);
	assign exc = dlws_exc(|r.term[`DLWS_TERM_ODT], wl, on_d);
	assign post = r.io[`DLWS_IO_WPST] ? `DLWS_POST_EXT : `DLWS_POST_STD;
	assign wr_end = (off_d > wl + dlws_half(r.wr_bl32) + post) ? off_d
		: dlws_cnt_t'(wl + dlws_half(r.wr_bl32) + post);
	assign rd_end = rl + dlws_half(r.rd_bl32) + `DLWS_ONE + exc;
	assign busy = r.pend | r.cs | r.wr_act | r.rd_act;
	assign band_ok = (band == r.band_lim);
	assign fall = (r.div == `DLWS_CK_LAST);
	assign is_rw = (pwdata[`DLWS_CMD_CODE] == cmd_wr)
		|| (pwdata[`DLWS_CMD_CODE] == cmd_mwr)
		|| (pwdata[`DLWS_CMD_CODE] == cmd_rd);

	// ==========================================================
	// next state
	always_comb begin
		n = r;
		n.div = r.div + 4'h1;
		n.ck = n.div[3];
		wr_burst = 1'b0;
		rd_win = 1'b0;
		// setup phase: decode, refuse, capture read data
		if (psel && !penable) begin
			n.err = 1'b0;
			n.rdata = 32'h0000_0000;
			unique case (paddr)
				`DLWS_OFF_CTRL: n.rdata = {28'h000_0000, r.band_lim, r.cke};
				`DLWS_OFF_CMD: n.rdata = {16'h0000, r.p_op, 1'b0, r.p_ma,
					r.p_bl32, r.p_ap, r.p_cmd};
				`DLWS_OFF_STATUS: begin
					n.rdata = {27'h000_0000, r.dqs_oe, band_ok, r.rd_act,
						r.wr_act, busy};
					n.err = pwrite;
				end
				default: n.err = 1'b1;
			endcase
			// one command at a time keeps command spacing intact
			if (pwrite && paddr == `DLWS_OFF_CMD)
				n.err = busy | (is_rw & ~band_ok);
		end
		// access phase: a write takes effect here only
		if (psel && penable && pwrite && !r.err) begin
			if (paddr == `DLWS_OFF_CTRL) begin
				n.cke = pwdata[`DLWS_CTRL_CKE];
				n.band_lim = pwdata[`DLWS_CTRL_BAND];
			end else if (paddr == `DLWS_OFF_CMD) begin
				n.pend = 1'b1;
				n.p_cmd = dlws_cmd_e'(pwdata[`DLWS_CMD_CODE]);
				n.p_ap = pwdata[`DLWS_CMD_AP];
				n.p_bl32 = pwdata[`DLWS_CMD_BL32];
				n.p_ma = pwdata[`DLWS_CMD_MA];
				n.p_op = pwdata[`DLWS_CMD_OP];
			end
		end
		// link side moves at the ck fall so fields are steady at rise
		if (fall) begin
			n.cs = 1'b0;
			if (r.wr_act) begin
				n.wr_age = r.wr_age + `DLWS_ONE;
				n.wr_act = (n.wr_age < wr_end);
			end
			if (r.rd_act) begin
				n.rd_age = r.rd_age + `DLWS_ONE;
				n.rd_act = (n.rd_age < rd_end);
			end
			if (r.pend) begin
				n.pend = 1'b0;
				n.cs = 1'b1;
				n.l_cmd = r.p_cmd;
				n.l_ap = r.p_ap;
				n.l_bl32 = r.p_bl32;
				n.l_ma = r.p_ma;
				n.l_op = r.p_op;
				unique case (r.p_cmd)
					cmd_wr, cmd_mwr: begin
						n.wr_act = 1'b1;
						n.wr_age = 8'h00;
						n.wr_bl32 = r.p_bl32;
					end
					cmd_rd: begin
						n.rd_act = 1'b1;
						n.rd_age = 8'h00;
						n.rd_bl32 = r.p_bl32;
					end
					cmd_mrw: begin
						unique case (r.p_ma)
							`DLWS_MA_LAT: n.lat = r.p_op;
							`DLWS_MA_IO: n.io = r.p_op;
							`DLWS_MA_TERM: n.term = r.p_op;
							default: ;
						endcase
					end
					cmd_des: ;
					default: n.cs = 1'b0;
				endcase
			end
		end
		// write burst: preamble from wl-2, toggles through postamble
		wr_burst = n.wr_act && n.wr_age >= wl - `DLWS_WPRE
			&& n.wr_age < wl + dlws_half(n.wr_bl32) + post;
		rd_win = n.rd_act && n.rd_age >= rl - `DLWS_ONE
			&& n.rd_age < rd_end;
		n.dqs_oe = 1'b1;
		n.dqs_t = 1'b0;
		if (rd_win) begin
			n.dqs_oe = 1'b0;
		end else if (wr_burst) begin
			n.dqs_t = n.ck;
		end else if (r.lat[`DLWS_LAT_WMODE]) begin
			// held apart from the command until the off delay
			n.dqs_oe = n.wr_act && n.wr_age < off_d;
		end else begin
			// complement high whenever cke is high
			n.dqs_oe = n.cke;
		end
		n.dqs_c = n.dqs_oe & ~n.dqs_t;
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end

	// ==========================================================
	// outputs
	assign prdata = r.rdata;
	assign pready = psel & penable;
	assign pslverr = psel & penable & r.err;
	assign link.ck = r.ck;
	assign link.cke = r.cke;
	assign link.cs = r.cs;
	assign link.cmd = r.l_cmd;
	assign link.ap = r.l_ap;
	assign link.bl32 = r.l_bl32;
	assign link.ma = r.l_ma;
	assign link.op = r.l_op;
	assign link.h_t = r.dqs_t;
	assign link.h_c = r.dqs_c;
	assign link.h_oe = r.dqs_oe;
endmodule

/* verification/dlws_link_sva.sv */
// ==========================================================
// link checker: clock shape, command framing and strobe drive
// assumes pclk drives both ends and ck is pclk divided by 16
`timescale 1ns/100ps
module dlws_link_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ck,
	input wire logic cs,
	input wire logic [2:0] cmd,
	input wire logic [7:0] op,
	input wire logic h_t,
	input wire logic h_c,
	input wire logic h_oe,
	input wire logic d_t,
	input wire logic d_c,
	input wire logic d_oe
);
	// ==========================================================
	// one domain, so one clock and one reset for all properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// host strobe is always a true pair while driven
	a_host_pair_diff: assert property (h_oe |-> h_c != h_t)
		else $error("host strobe pair not differential");
	// device read strobe is always a true pair while driven
	a_dev_pair_diff: assert property (d_oe |-> d_c != d_t)
		else $error("device strobe pair not differential");
	// handover: never both ends on the pair at once
	a_no_drive_clash: assert property (!(h_oe && d_oe))
		else $error("both ends drive the strobe pair");
	// a command stands exactly one ck period of 16 pclk
	a_cs_one_period: assert property ($rose(cs) |-> cs[*8] ##8 cs ##1 !cs)
		else $error("command strobe length wrong");
	// commands launch on the falling ck edge only
	a_cs_at_fall: assert property ($rose(cs) |-> $fell(ck))
		else $error("command not launched at ck fall");
	// ck high half is eight pclk
	a_ck_high_len: assert property ($rose(ck) |-> ck[*8] ##1 !ck)
		else $error("ck high phase length wrong");
	// ck low half is at least eight pclk
	a_ck_low_len: assert property ($fell(ck) |-> !ck[*8])
		else $error("ck low phase too short");
	// fields hold still while a command stands
	a_cmd_held: assert property (cs && !$rose(cs) |-> $stable(op) &&
		$stable(cmd))
		else $error("command fields changed mid command");

	// main scenarios reached
	c_write_cmd: cover property ($rose(cs) && cmd == 3'h1);
	c_read_strobe: cover property ($rose(d_oe));
	c_host_strobe: cover property ($rose(h_oe));
endmodule

/* verification/test_dram_latency_and_write_strobe_ctrl.sv */
// ==========================================================
// bench for the host and dram ends joined by the link interface
// assumes apb with zero wait states and a free running pclk
`timescale 1ns/100ps
module test_dram_latency_and_write_strobe_ctrl import dlws_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic er;
	logic [7:0] lat_cfg, io_cfg, term_cfg, read_latency, write_latency;
	logic odt_on, wpst_ext, precharge_start, strobe_fault;
	int mismatches = 0;
	int compares = 0;
	logic [31:0] seed = 32'hCEB1; // fixed so runs repeat
	// band tables: rl, rl dbi, wl a, wl b, write recovery, rd to pre
	localparam int T [6][8] = '{'{6, 10, 14, 20, 24, 28, 32, 36},
		'{6, 12, 16, 22, 28, 32, 36, 40}, '{4, 6, 8, 10, 12, 14, 16, 18},
		'{4, 8, 12, 18, 22, 26, 30, 34}, '{6, 10, 16, 20, 24, 30, 34, 40},
		'{8, 8, 8, 8, 10, 12, 14, 16}};

	// ==========================================================
	// design under test
	dlws_link_if dlws_link_if_i();
	dlws_host dlws_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(dlws_link_if_i));
	dlws_dev dlws_dev_i (.pclk(pclk), .presetn(presetn),
		.link(dlws_link_if_i), .lat_cfg(lat_cfg), .io_cfg(io_cfg),
		.term_cfg(term_cfg), .read_latency(read_latency),
		.write_latency(write_latency), .odt_on(odt_on), .wpst_ext(wpst_ext),
		.precharge_start(precharge_start), .strobe_fault(strobe_fault),
		.read_strobe_on());
	dlws_link_sva dlws_link_sva_i (.pclk(pclk), .presetn(presetn),
		.ck(dlws_link_if_i.ck), .cs(dlws_link_if_i.cs),
		.cmd(dlws_link_if_i.cmd), .op(dlws_link_if_i.op),
		.h_t(dlws_link_if_i.h_t), .h_c(dlws_link_if_i.h_c),
		.h_oe(dlws_link_if_i.h_oe), .d_t(dlws_link_if_i.d_t),
		.d_c(dlws_link_if_i.d_c), .d_oe(dlws_link_if_i.d_oe));

	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic print_verdict();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// values are zero extended, so x or z never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic hang();
		mismatches++;
		print_verdict();
	endtask

	// one apb transfer; entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1)
			hang();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// poll status until busy and both windows are clear
	task automatic wait_idle();
		int n;
		for (n = 0; n < 1000; n++) begin
			apb(1'b0, 12'h008, 32'h0, rd, er);
			if (rd[2:0] === 3'h0)
				break;
		end
		if (n == 1000)
			hang();
	endtask

	task automatic mrw(input logic [1:0] ma, input logic [7:0] op);
		apb(1'b1, 12'h004, {16'h0, op, 1'b0, ma, 5'h04}, rd, er);
		chk(er, 0);
		wait_idle();
	endtask

	// auto precharge command; ck rises from the command tick are counted
	task automatic pre(input logic [2:0] code, input logic bl, input int ex);
		int n, cnt;
		logic ckq;
		cnt = 0;
		ckq = 1'b0;
		apb(1'b1, 12'h004, {27'h0, bl, 1'b1, code}, rd, er);
		for (n = 0; n < 4000 && precharge_start !== 1'b1; n++) begin
			@(posedge pclk);
			if (cnt > 0 || dlws_link_if_i.cs === 1'b1)
				cnt += int'(dlws_link_if_i.ck && !ckq);
			ckq = dlws_link_if_i.ck;
		end
		if (n == 4000)
			hang();
		chk(cnt - 1, ex);
		wait_idle();
	endtask

	// ==========================================================
	// clock and main sequence
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		logic [31:0] r;
		logic [7:0] lat, io, trm;
		logic [2:0] b;
		logic bl;
		int it, wl, hf;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// refusals: unmapped place and read-only status
		apb(1'b0, 12'h00C, 32'h0, rd, er);
		chk(er, 1);
		apb(1'b1, 12'h008, 32'h0, rd, er);
		chk(er, 1);
		apb(1'b1, 12'h000, 32'h1, rd, er);
		mrw(2'h0, 8'h00);
		apb(1'b1, 12'h004, 32'h0, rd, er); // idle command, accepted
		chk(er, 0);
		// the next command would be refused while this one stands
		wait_idle();
		// every band once, other fields random
		for (it = 0; it < 8; it++) begin
			r = rnd();
			b = it[2:0];
			bl = r[8];
			lat = {r[0], r[1], 3'h0, b};
			io = {1'b0, r[2], 4'h0, r[3], 1'b0};
			trm = {5'h0, r[6:4]};
			apb(1'b1, 12'h000, {28'h0, b, 1'b1}, rd, er);
			mrw(2'h0, lat);
			mrw(2'h1, io);
			mrw(2'h2, trm);
			chk(lat_cfg, lat);
			chk(io_cfg, io);
			chk(term_cfg, trm);
			chk(read_latency, T[io[6]][b]);
			wl = T[2 + int'(lat[6])][b];
			chk(write_latency, wl);
			chk(odt_on, |trm);
			chk(wpst_ext, io[1]);
			// read-based idle: complement high, true low
			if (!lat[7])
				chk({dlws_link_if_i.dqs_t, dlws_link_if_i.dqs_c}, 2'b01);
			else
				chk({dlws_link_if_i.dqs_t, dlws_link_if_i.dqs_c}, 2'b00);
			hf = bl ? 16 : 8;
			pre(r[7] ? 3'h2 : 3'h1, bl, wl + 1 + hf + T[4][b]);
			pre(3'h3, bl, hf + T[5][b] + (bl ? 8 : 0));
			// band limit other than the programmed band refuses a read
			apb(1'b1, 12'h000, {28'h0, b ^ 3'h1, 1'b1}, rd, er);
			apb(1'b1, 12'h004, 32'h3, rd, er);
			chk(er, 1);
			chk(strobe_fault, 0);
			// status: idle, band mismatch, host pair drive by mode
			apb(1'b0, 12'h008, 32'h0, rd, er);
			chk(rd[4:0], {~lat[7], 4'h0});
			apb(1'b0, 12'h000, 32'h0, rd, er);
			chk(rd, {28'h0, b ^ 3'h1, 1'b1});
		end
		// clock enable low: host lets the pair go, no fault is flagged
		apb(1'b1, 12'h000, 32'h0, rd, er);
		repeat (40) @(posedge pclk);
		chk({dlws_link_if_i.dqs_t, dlws_link_if_i.dqs_c}, 2'b00);
		chk(strobe_fault, 0);
		print_verdict();
	end
endmodule
